// ==== bench/core_model.sv ====
`timescale 1ns/1ps
// ---------------------------------------------------------------
// core side: accepts each standing request ackLag+1 cycles after it rises
// handler words are software's, each with bit 0 set; this model
// reads no table, it only paces the acknowledge
// ---------------------------------------------------------------
module core_model (
  input  wire logic       mclk,
  input  wire logic       rst_b,
  input  wire logic       reqUp,
  input  wire logic [1:0] ackLag,
  output logic            takeAck
);
  logic [1:0] waitQ;
  // ack is a single pulse, never raised without a standing request
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      waitQ   <= '0;
      takeAck <= 1'b0;
    end else if (takeAck || !reqUp) begin
      waitQ   <= '0;
      takeAck <= 1'b0;
    end else if (waitQ == ackLag) begin
      takeAck <= 1'b1;
    end else begin
      waitQ <= waitQ + 2'd1;
    end
  end
endmodule : core_model

// ==== bench/exc_vec_properties.sv ====
`timescale 1ns/1ps
module exc_vec_properties (
  input wire logic                  mclk,
  input wire logic                  rst_b,
  input wire logic                  vtorWrite,
  input wire logic                  vtorPriv,
  input wire logic [31:0]           vtorValue,
  input wire logic                  takeAck,
  input wire exc_vec_pkg::vec_req_s vecReq,
  input wire logic                  vecValid,
  input wire logic                  spFetch,
  input wire logic [31:0]           vectorTableOffset,
  input wire logic [5:0]            activeNum,
  input wire logic signed [3:0]     activePri,
  input wire logic                  vtorReject
);
  import exc_vec_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  logic badVtor;
  assign badVtor = vtorWrite && (!vtorPriv || vtorValue < VTOR_MIN
                   || vtorValue > VTOR_MAX);
  // ---------------------------------------------------------------
  // table base
  // ---------------------------------------------------------------
  base_hold_a: assert property (
    !vtorWrite |=> $stable(vectorTableOffset)) else $error("base moved");
  vtor_reject_a: assert property (
    badVtor |=> vtorReject && $stable(vectorTableOffset))
    else $error("bad base write not refused");
  vtor_take_a: assert property (
    vtorWrite && !badVtor |=> !vtorReject
    && vectorTableOffset == ($past(vtorValue) & VTOR_ALIGN))
    else $error("good base write not taken");
  // ---------------------------------------------------------------
  // vector requests
  // ---------------------------------------------------------------
  vec_addr_a: assert property (
    vecValid |-> vecReq.vecAddr
    == vectorTableOffset + {24'h0, vecReq.excNum, 2'b00})
    else $error("vector address wrong");
  sp_word_a: assert property (
    spFetch |-> vecReq.vecAddr == vectorTableOffset)
    else $error("stack word address wrong");
  no_reserved_a: assert property (
    vecValid |-> vecReq.excNum != 6'h00 && vecReq.excNum != 6'h19)
    else $error("reserved line requested");
  req_stands_a: assert property (
    vecValid && !takeAck |=> vecValid && $stable(vecReq))
    else $error("request dropped before ack");
  ack_active_a: assert property (
    vecValid && takeAck |=> !vecValid ##1
    activeNum == $past(vecReq.excNum, 2))
    else $error("taken exception not active");
  nmi_urgent_a: assert property (
    vecValid && vecReq.excNum == EXC_NMI |-> activePri > FIXPRI_NMI)
    else $error("nmi requested under equal priority");
  hard_fixed_a: assert property (
    vecValid && takeAck && vecReq.excNum == EXC_HARD
    |-> ##2 activePri == FIXPRI_HARD) else $error("hard fault priority");
  cover property (vecValid && takeAck);
  cover property (spFetch && takeAck);
  cover property (vtorReject);
endmodule : exc_vec_properties

// ==== bench/exception_priority_vector_logic_bench.sv ====
`timescale 1ns/1ps
module exception_priority_vector_logic_bench;
  import exc_vec_pkg::*;
  localparam int N = 30;
  logic              mclk, rst_b, nmiReq, hardFaultReq, sysExcSet;
  logic              priWrite, vtorWrite, vtorPriv, excReturn, takeAck;
  logic              vecValid, spFetch, vtorReject;
  logic [N-1:0]      irqReq;
  logic [5:0]        sysExcNum, priNum, activeNum;
  logic [2:0]        priValue;
  logic [1:0]        ackLag;
  logic [31:0]       vtorValue, vectorTableOffset, base;
  logic signed [3:0] activePri;
  vec_req_s          vecReq;
  int                err_count = 0;
  int                tests_run = 0;
  // exception number beside its table offset
  logic [37:0] rows [7] = '{{6'h04, 32'h0000_0010}, {6'h0B, 32'h0000_002C},
    {6'h0E, 32'h0000_0038}, {6'h0F, 32'h0000_003C}, {6'h10, 32'h0000_0040},
    {6'h18, 32'h0000_0060}, {6'h2D, 32'h0000_00B4}};

  exception_priority_vector_logic #(.IRQ_COUNT(N))
    i_exception_priority_vector_logic (.mclk, .rst_b, .irqReq, .nmiReq,
    .hardFaultReq, .sysExcSet, .sysExcNum, .irqEnable({N{1'b1}}),
    .priWrite, .priNum, .priValue, .vtorWrite, .vtorPriv, .vtorValue,
    .takeAck, .excReturn, .vecReq, .vecValid, .spFetch,
    .vectorTableOffset, .activeNum, .activePri, .vtorReject);
  core_model i_core_model (.mclk, .rst_b, .reqUp(vecValid | spFetch),
    .ackLag, .takeAck);

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic tick(int n = 1);
    repeat (n) @(posedge mclk);
    #5;
  endtask : tick
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_of_test
  task automatic waitSig(bit sp, bit lvl);
    int k;
    for (k = 0; k < 40 && (sp ? spFetch : vecValid) !== lvl; k++)
      tick();
    if (k == 40) begin
      chk(sp ? "spFetch" : "vecValid", 32'(lvl), 32'(~lvl));
      end_of_test();
    end
  endtask : waitSig
  task automatic pend(logic [5:0] n);
    if (n > 6'd15) begin
      irqReq[n - 6'd16] = 1'b1;
    end else begin
      sysExcSet = 1'b1;
      sysExcNum = n;
      tick();
      sysExcSet = 1'b0;
    end
  endtask : pend
  task automatic take(logic [5:0] n, logic [31:0] ofs);
    waitSig(0, 1);
    chk("excNum", 32'(n), 32'(vecReq.excNum));
    chk("vecAddr", base + ofs, vecReq.vecAddr);
    waitSig(0, 0);
    tick();
    chk("activeNum", 32'(n), 32'(activeNum));
    if (n > 6'd15) irqReq[n - 6'd16] = 1'b0;
  endtask : take
  task automatic done();
    excReturn = 1'b1;
    tick();
    excReturn = 1'b0;
    // one low edge before the next pulse
    tick();
  endtask : done
  task automatic setPri(logic [5:0] n, logic [2:0] p);
    priWrite = 1'b1;
    priNum = n;
    priValue = p;
    tick();
    priWrite = 1'b0;
    tick();
  endtask : setPri
  task automatic vtor(bit priv, logic [31:0] v, bit rej);
    logic [31:0] was;
    was = vectorTableOffset;
    vtorWrite = 1'b1;
    vtorPriv = priv;
    vtorValue = v;
    tick();
    vtorWrite = 1'b0;
    chk("vtorReject", 32'(rej), 32'(vtorReject));
    chk("tableBase", rej ? was : v, vectorTableOffset);
    tick();
  endtask : vtor
  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    {nmiReq, hardFaultReq, sysExcSet, priWrite, vtorWrite, vtorPriv} = '0;
    {excReturn, irqReq, sysExcNum, priNum, priValue, vtorValue} = '0;
    base = '0;
    ackLag = 2'd1;
    rst_b = 1'b0;
    tick(16);
    rst_b = 1'b1;
    waitSig(1, 1);
    chk("spAddr", 32'h0000_0000, vecReq.vecAddr);
    chk("tableBase", VTOR_RESET, vectorTableOffset);
    waitSig(1, 0);
    foreach (rows[i]) begin
      ackLag = 2'(i);
      pend(rows[i][37:32]);
      take(rows[i][37:32], rows[i][31:0]);
      done();
    end
    vtor(1'b0, 32'h0000_0200, 1'b1);
    vtor(1'b1, 32'h0000_0000, 1'b1);
    vtor(1'b1, 32'h4000_0000, 1'b1);
    vtor(1'b1, 32'h0000_0100, 1'b0);
    vtor(1'b1, 32'h3FFF_FF00, 1'b0);
    vtor(1'b1, 32'h0000_0200, 1'b0);
    base = 32'h0000_0200;
    irqReq[1:0] = 2'b11;
    take(6'h10, 32'h0000_0040);
    done();
    take(6'h11, 32'h0000_0044);
    done();
    setPri(6'h10, 3'd5);
    setPri(6'h11, 3'd2);
    setPri(6'h03, 3'd7);
    tick(4);
    irqReq[1:0] = 2'b11;
    take(6'h11, 32'h0000_0044);
    done();
    take(6'h10, 32'h0000_0040);
    done();
    irqReq[2] = 1'b1;
    take(6'h12, 32'h0000_0048);
    pend(EXC_TICK);
    repeat (8) begin
      tick();
      chk("vecValid", 32'h0, 32'(vecValid));
    end
    nmiReq = 1'b1;
    take(EXC_NMI, 32'h0000_0008);
    chk("activePri", 32'(FIXPRI_NMI), 32'(activePri));
    done();
    nmiReq = 1'b0;
    hardFaultReq = 1'b1;
    tick();
    hardFaultReq = 1'b0;
    take(EXC_HARD, 32'h0000_000C);
    chk("activePri", 32'(FIXPRI_HARD), 32'(activePri));
    done();
    done();
    take(EXC_TICK, 32'h0000_003C);
    done();
    rst_b = 1'b0;
    tick(2);
    chk("tableBase", VTOR_RESET, vectorTableOffset);
    rst_b = 1'b1;
    waitSig(1, 1);
    chk("spAddr", VTOR_RESET, vecReq.vecAddr);
    end_of_test();
  end
endmodule : exception_priority_vector_logic_bench

bind exception_priority_vector_logic exc_vec_properties i_exc_vec_properties
  (.mclk, .rst_b, .vtorWrite, .vtorPriv, .vtorValue, .takeAck, .vecReq,
  .vecValid, .spFetch, .vectorTableOffset, .activeNum, .activePri,
  .vtorReject);

// ==== hw/exc_arbiter.sv ====
`timescale 1ns/1ps
// ---------------------------------------------------------------
// combinational winner search over pending exceptions
// ---------------------------------------------------------------
module exc_arbiter #(
  parameter int unsigned N = 48
) (
  input  wire logic [N-1:0]        pendVec,
  input  wire logic [N*4-1:0]      priFlat,
  output logic                     found,
  output logic [5:0]               winNum,
  output logic signed [3:0]        winPri
);
  import exc_vec_pkg::*;

  if (N > 64 || N < 17) begin : gChk
    $error("exc_arbiter: N out of range");
  end

  logic               f [0:N];
  logic [5:0]         n [0:N];
  logic signed [3:0]  p [0:N];

  assign f[N] = 1'b0;
  assign n[N] = 6'h00;
  assign p[N] = PRI_IDLE;

  // scan downward so the lowest number wins a tie [R13]
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : gScan
      logic signed [3:0] pg;
      logic              take;
      assign pg   = $signed(priFlat[g*4 +: 4]);
      // lower value is more urgent; tie keeps lower index [R10] [R13]
      assign take = pendVec[g] && (!f[g+1] || pg <= p[g+1]);
      assign f[g] = take ? 1'b1 : f[g+1];
      assign n[g] = take ? 6'(g) : n[g+1];
      assign p[g] = take ? pg : p[g+1];
    end
  endgenerate

  assign found  = f[0];
  assign winNum = n[0];
  assign winPri = p[0];

endmodule : exc_arbiter

// ==== hw/exc_vec_pkg.sv ====
package exc_vec_pkg;

  // ---------------------------------------------------------------
  // exception numbers
  // ---------------------------------------------------------------
  localparam int unsigned NUM_EXC      = 48;
  localparam int unsigned EXC_W        = 6;
  localparam int unsigned IRQ_BASE_NUM = 16;
  localparam int unsigned NUM_IRQ      = 32;
  localparam logic [5:0]  EXC_RESET    = 6'h01;
  localparam logic [5:0]  EXC_NMI      = 6'h02;
  localparam logic [5:0]  EXC_HARD     = 6'h03;
  localparam logic [5:0]  EXC_MEMMAN   = 6'h04;
  localparam logic [5:0]  EXC_BUSFLT   = 6'h05;
  localparam logic [5:0]  EXC_USAGE    = 6'h06;
  localparam logic [5:0]  EXC_SVC      = 6'h0B;
  localparam logic [5:0]  EXC_DEBUG    = 6'h0C;
  localparam logic [5:0]  EXC_PENDABLE_SERVICE_REQUEST   = 6'h0E;
  localparam logic [5:0]  EXC_TICK     = 6'h0F;
  localparam int unsigned IRQ_RESERVED = 9;

  // ---------------------------------------------------------------
  // priority encoding: 4-bit signed, fixed ones negative
  // ---------------------------------------------------------------
  localparam int unsigned PRI_W      = 3;
  localparam logic [2:0]  PRI_RESET  = 3'h0;
  localparam logic signed [3:0] FIXPRI_RESET = -4'sd3;
  localparam logic signed [3:0] FIXPRI_NMI   = -4'sd2;
  localparam logic signed [3:0] FIXPRI_HARD  = -4'sd1;
  localparam logic signed [3:0] PRI_IDLE     = 4'sd7 + 4'sd0;

  // ---------------------------------------------------------------
  // vector table
  // ---------------------------------------------------------------
  localparam logic [31:0] VTOR_RESET = 32'h0000_0000;
  localparam logic [31:0] VTOR_MIN   = 32'h0000_0100;
  localparam logic [31:0] VTOR_MAX   = 32'h3FFF_FF00;
  localparam logic [31:0] VTOR_ALIGN = 32'hFFFF_FF00;
  localparam logic [31:0] IRQ0_OFS   = 32'h0000_0040;

  typedef struct packed {
    logic [5:0]  excNum;
    logic [31:0] vecAddr;
  } vec_req_s;

  typedef struct packed {
    logic       valid;
    logic [5:0] excNum;
  } exc_evt_s;

endpackage : exc_vec_pkg

// ==== hw/exception_priority_vector_logic.sv ====
`timescale 1ns/1ps
// What this block does
// R1: every configurable priority is zero after reset until written.
// R2: vector sits at four times its number; irq n is number 16+n at 0x40+.
// R3: pendable service request is 14, system tick 15, both programmable.
// R4: irq 0-4 ports, 5-6 uarts, 7 sync serial, 8 i2c, 9 reserved.
// R5: table word 0 is the reset stack pointer, then handler addresses.
// R6: software stores every handler address with bit 0 set.
// R7: reset places the table base at zero whatever was written before.
// R8: only privileged writes move the base, within 0x100..0x3FFFFF00.
// R9: software aligns a new base to 256 bytes.
// R10: a numerically lower priority is more urgent.
// R11: reset, hard fault and nmi are fixed; the rest are configurable.
// R12: configurable priorities are 0-7, so fixed ones always outrank them.
// R13: on equal priority the lowest exception number is taken first.
// R14: a running handler is preempted only by a strictly more urgent one.
// R15: an equal-priority arrival does not preempt and stays pending.
// R16: nmi is fixed at -2 and unmaskable, hard fault -1, reset -3.
module exception_priority_vector_logic #(
  parameter int unsigned IRQ_COUNT = 30
) (
  input  wire logic                      mclk,
  input  wire logic                      rst_b,
  // peripheral and system requests
  input  wire logic [IRQ_COUNT-1:0]      irqReq,
  input  wire logic                      nmiReq,
  input  wire logic                      hardFaultReq,
  input  wire logic                      sysExcSet,
  input  wire logic [5:0]                sysExcNum,
  input  wire logic [IRQ_COUNT-1:0]      irqEnable,
  // priority configuration
  input  wire logic                      priWrite,
  input  wire logic [5:0]                priNum,
  input  wire logic [2:0]                priValue,
  // vector table offset configuration
  input  wire logic                      vtorWrite,
  input  wire logic                      vtorPriv,
  input  wire logic [31:0]               vtorValue,
  // core handshake
  input  wire logic                      takeAck,
  input  wire logic                      excReturn,
  output exc_vec_pkg::vec_req_s          vecReq,
  output logic                           vecValid,
  output logic                           spFetch,
  output logic [31:0]                    vectorTableOffset,
  output logic [5:0]                     activeNum,
  output logic signed [3:0]              activePri,
  output logic                           vtorReject
);
  import exc_vec_pkg::*;

  // line 9 must exist, and the table holds 32 lines at most
  if (IRQ_COUNT > NUM_IRQ || IRQ_COUNT < IRQ_RESERVED + 1) begin : gChk
    $error("IRQ_COUNT out of range");
  end

  // ---------------------------------------------------------------
  // input synchronisers (asynchronous sources)
  // ---------------------------------------------------------------
  localparam int unsigned SW = IRQ_COUNT + 1;
  logic [SW-1:0] syn1_q, syn2_q, syn3_q, lvl_q;
  logic [SW-1:0] rawIn;
  assign rawIn = {nmiReq, irqReq};

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      syn1_q <= '0;
      syn2_q <= '0;
      syn3_q <= '0;
    end else begin
      syn1_q <= rawIn;
      syn2_q <= syn1_q;
      syn3_q <= syn2_q;
    end
  end

  // a change counts only once the last two stages agree
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      lvl_q <= '0;
    end else begin
      for (int i = 0; i < SW; i++) begin
        if (syn2_q[i] == syn3_q[i]) lvl_q[i] <= syn3_q[i];
      end
    end
  end

  // ---------------------------------------------------------------
  // priorities
  // ---------------------------------------------------------------
  logic [2:0] cfgPri_q [0:NUM_EXC-1];
  logic       priWritable;

  // fixed ones never take a write [R11]
  assign priWritable = priWrite && priNum > EXC_HARD
                       && priNum < 6'(NUM_EXC);

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < NUM_EXC; i++) cfgPri_q[i] <= PRI_RESET; // [R1]
    end else if (priWritable) begin
      cfgPri_q[priNum] <= priValue; // 3-bit field caps at 7 [R12]
    end
  end

  logic [NUM_EXC*4-1:0] priFlat;
  genvar g;
  generate
    for (g = 0; g < NUM_EXC; g++) begin : gPri
      if (g == EXC_RESET) begin : gR
        assign priFlat[g*4 +: 4] = FIXPRI_RESET; // [R16]
      end else if (g == EXC_NMI) begin : gN
        assign priFlat[g*4 +: 4] = FIXPRI_NMI; // [R16]
      end else if (g == EXC_HARD) begin : gH
        assign priFlat[g*4 +: 4] = FIXPRI_HARD; // [R16]
      end else begin : gC
        // zero-extended, so always above any fixed one [R12]
        assign priFlat[g*4 +: 4] = {1'b0, cfgPri_q[g]};
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // pending state
  // ---------------------------------------------------------------
  logic [NUM_EXC-1:0] pend_q, pendSet, eligible;
  logic [SW-1:0]      lvlPrev_q;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) lvlPrev_q <= '0;
    else        lvlPrev_q <= lvl_q;
  end

  always_comb begin
    pendSet = '0;
    for (int i = 0; i < IRQ_COUNT; i++) begin
      // line 9 is unused [R4]
      if (i != IRQ_RESERVED && lvl_q[i] && !lvlPrev_q[i])
        pendSet[IRQ_BASE_NUM + i] = 1'b1; // [R2]
    end
    if (lvl_q[SW-1] && !lvlPrev_q[SW-1]) pendSet[EXC_NMI] = 1'b1;
    if (hardFaultReq) pendSet[EXC_HARD] = 1'b1;
    // 14 and 15 arrive here asynchronously to code [R3]
    if (sysExcSet && sysExcNum > EXC_HARD && sysExcNum < IRQ_BASE_NUM[5:0])
      pendSet[sysExcNum] = 1'b1;
  end

  logic       found;
  logic [5:0] winNum;
  logic signed [3:0] winPri;
  logic       doTake;

  // a new arrival wins over the clear on the same edge
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pend_q <= '0;
    end else begin
      for (int i = 0; i < NUM_EXC; i++) begin
        if (pendSet[i])
          pend_q[i] <= 1'b1; // equal-priority arrival waits [R15]
        // clear the one offered, not the winner, which may have moved on
        else if (vecValid && takeAck && vecReq.excNum == 6'(i))
          pend_q[i] <= 1'b0;
      end
    end
  end

  always_comb begin
    eligible = pend_q;
    for (int i = 0; i < IRQ_COUNT; i++) begin
      if (!irqEnable[i]) eligible[IRQ_BASE_NUM + i] = 1'b0;
    end
    eligible[0] = 1'b0;
  end

  exc_arbiter #(
    .N(NUM_EXC)
  ) uArb (
    .pendVec(eligible),
    .priFlat(priFlat),
    .found  (found),
    .winNum (winNum),
    .winPri (winPri)
  );

  // ---------------------------------------------------------------
  // active stack: nesting depth bounded by distinct levels
  // ---------------------------------------------------------------
  localparam int unsigned DEPTH = 12;
  logic [5:0]        stkNum_q [0:DEPTH-1];
  logic signed [3:0] stkPri_q [0:DEPTH-1];
  logic [3:0]        sp_q;
  logic signed [3:0] curPri;

  assign curPri = (sp_q == 4'h0) ? PRI_IDLE : stkPri_q[sp_q - 4'h1];

  // strictly more urgent only, thread mode takes anything [R14] [R15]
  assign doTake = found && (sp_q == 4'h0 || winPri < curPri)
                  && sp_q < 4'(DEPTH);

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sp_q <= 4'h0;
      for (int i = 0; i < DEPTH; i++) begin
        stkNum_q[i] <= 6'h00;
        stkPri_q[i] <= 4'sd0;
      end
    end else if (vecValid && takeAck) begin
      stkNum_q[sp_q] <= vecReq.excNum;
      stkPri_q[sp_q] <= priFlat[vecReq.excNum*4 +: 4];
      sp_q           <= sp_q + 4'h1;
    end else if (excReturn && sp_q != 4'h0) begin
      sp_q <= sp_q - 4'h1;
    end
  end

  // ---------------------------------------------------------------
  // vector table offset
  // ---------------------------------------------------------------
  logic vtorOk;
  // privileged, in range; low byte dropped for alignment [R8] [R9]
  assign vtorOk = vtorPriv && vtorValue >= VTOR_MIN
                  && vtorValue <= VTOR_MAX;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      vectorTableOffset <= VTOR_RESET; // [R7]
      vtorReject        <= 1'b0;
    end else begin
      vtorReject <= vtorWrite && !vtorOk;
      if (vtorWrite && vtorOk)
        vectorTableOffset <= vtorValue & VTOR_ALIGN; // [R8]
    end
  end

  // ---------------------------------------------------------------
  // vector request to the core
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_BOOT  = 2'b00,
    ST_STACK = 2'b01,
    ST_IDLE  = 2'b10,
    ST_OFFER = 2'b11
  } req_state_e;

  req_state_e reqState_q;

  // word 0 after reset is the stack pointer fetch [R5]
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      reqState_q <= ST_BOOT;
      spFetch    <= 1'b0;
      vecValid   <= 1'b0;
      vecReq     <= '0;
    end else begin
      case (reqState_q)
        ST_BOOT: begin
          reqState_q     <= ST_STACK;
          spFetch        <= 1'b1;
          vecReq.excNum  <= 6'h00;
          vecReq.vecAddr <= vectorTableOffset;
        end
        ST_STACK: begin
          if (takeAck) begin
            reqState_q <= ST_IDLE;
            spFetch    <= 1'b0;
          end
        end
        // winner tracked every idle cycle, frozen once offered
        ST_IDLE: begin
          vecReq.excNum  <= winNum;
          // four bytes per vector number [R2]
          vecReq.vecAddr <= vectorTableOffset + {24'h00_0000, winNum, 2'b00};
          if (doTake) begin
            reqState_q <= ST_OFFER;
            vecValid   <= 1'b1;
          end
        end
        // request stands untouched until the core takes it; a more
        // urgent arrival meanwhile waits for the next offer
        ST_OFFER: begin
          if (takeAck) begin
            reqState_q <= ST_IDLE;
            vecValid   <= 1'b0;
          end
        end
        default: begin
          reqState_q <= ST_BOOT;
          spFetch    <= 1'b0;
          vecValid   <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      activeNum <= 6'h00;
      activePri <= PRI_IDLE;
    end else begin
      activeNum <= (sp_q == 4'h0) ? 6'h00 : stkNum_q[sp_q - 4'h1];
      activePri <= (sp_q == 4'h0) ? PRI_IDLE : stkPri_q[sp_q - 4'h1];
    end
  end

endmodule : exception_priority_vector_logic
